// >>> epi_defs.vh
// epi_defs.vh: constants for the external port pin interface
// assumes inclusion by bare name from the design files of this block
`ifndef EPI_DEFS_VH
`define EPI_DEFS_VH
// pin function selects, two bits per data byte lane group
`define EPI_FN_MEM        2'h0
`define EPI_FN_CAPTURE    2'h1
`define EPI_FN_FLAG       2'h2
`define EPI_FN_PWM        2'h3
// widths
`define EPI_ADDR_W        24
`define EPI_DATA_W        32
`define EPI_CAP_W         24
`define EPI_CAP_LSB       8
`define EPI_FLAG_N        4
// address bit that decodes the two bank selects
`define EPI_BANK_BIT      23
// sdram commands as {row, column, write} strobe levels
`define EPI_SD_NOP        3'h7
`define EPI_SD_ACT        3'h3
`define EPI_SD_READ       3'h5
`define EPI_SD_WRITE      3'h4
`define EPI_SD_PRE        3'h2
`define EPI_SD_REF        3'h1
`define EPI_SD_MRS        3'h0
// strobe setup time in ns and derived cycles at 40 MHz (25 ns)
`define EPI_CLK_PERIOD_NS 25
`define EPI_SETUP_NS      25
`define EPI_SETUP_CYC     ((`EPI_SETUP_NS + `EPI_CLK_PERIOD_NS - 1) / `EPI_CLK_PERIOD_NS)
// fifo shape
`define EPI_FIFO_DEPTH    4
`define EPI_FIFO_AW       2
`endif

// >>> epi_fifo.v
// epi_fifo.v: small flip-flop fifo with valid/ready on both sides
// assumes one clock, active-low async reset and a global clock enable
`timescale 1ns/100ps
module epi_fifo #(
  parameter WIDTH = 24,  // word width
  parameter DEPTH = 4,   // number of words
  parameter AW    = 2    // index width, log2 of depth
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_rstn,
  input  wire             i_ce,
  // fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // drain side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];  // storage words
  reg [AW-1:0]    wr_ptr;           // write index
  reg [AW-1:0]    rd_ptr;           // read index
  reg [AW:0]      count;            // words held
  wire            push;             // accepted write
  wire            pop;              // accepted read
  integer         k;                // reset loop index

  assign o_in_ready  = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_ce & i_in_valid & o_in_ready;
  assign pop         = i_ce & o_out_valid & i_out_ready;

  // pointer, count and storage update
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem[k] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem[wr_ptr] <= i_in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      // net change of the fill level
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // epi_fifo

// >>> epi_bank_dec.v
// epi_bank_dec.v: bank select decode from the access address
// assumes address and access-active arrive from the same register stage
`timescale 1ns/100ps
`include "epi_defs.vh"
module epi_bank_dec (
  // access inputs
  input  wire                    i_active,
  input  wire [`EPI_ADDR_W-1:0]  i_addr,
  // decoded selects
  output wire [1:0]              o_bank_select_n
);
  // selects follow the address combinationally, so they switch with it
  assign o_bank_select_n[0] = ~(i_active & ~i_addr[`EPI_BANK_BIT]);
  assign o_bank_select_n[1] = ~(i_active &  i_addr[`EPI_BANK_BIT]);
endmodule // epi_bank_dec

// >>> epi_port.v
// Function
// - drive access address on 24 address pins
// - data pins select memory, capture, flag, pwm
// - reset: memory function, flags 0-3 flag
// - capture channel samples data bits 31-8
// - low acknowledge stretches access until high
// - read strobe low for each word read
// - write strobe low for each word written
// - row/column strobes encode sdram command
// - bank select low during its access only
// - selects switch with address, even unconditioned
//
// epi_port.v: top of the external port pin interface
// assumes a core-side request port, synchronous pin inputs, one 40 MHz clock
`timescale 1ns/100ps
`include "epi_defs.vh"
module epi_port (
  // clock, reset, enable
  input  wire                    I_CORE_CLK,
  input  wire                    I_RSTN,
  input  wire                    i_CE,
  // core access request
  input  wire                    i_REQ_VALID,
  output wire                    o_REQ_READY,
  input  wire                    i_REQ_WRITE,
  input  wire                    i_REQ_COND,
  input  wire [`EPI_ADDR_W-1:0]  i_REQ_ADDR,
  input  wire [`EPI_DATA_W-1:0]  i_REQ_WDATA,
  output wire                    o_RSP_VALID,
  output wire [`EPI_DATA_W-1:0]  o_RSP_RDATA,
  // sdram command request
  input  wire                    i_SD_CMD_VALID,
  input  wire [2:0]              i_SD_CMD,
  // pin function select per 8-bit lane and capture enable
  input  wire [7:0]              i_PIN_FUNC,
  input  wire                    i_CAP_ENABLE,
  // flag and pwm sources
  input  wire [`EPI_FLAG_N-1:0]  i_FLAG_OUT,
  input  wire [`EPI_FLAG_N-1:0]  i_FLAG_OE,
  output wire [`EPI_FLAG_N-1:0]  o_FLAG_IN,
  input  wire [`EPI_DATA_W-1:0]  i_PWM,
  // parallel capture stream
  output wire                    o_CAP_VALID,
  input  wire                    i_CAP_READY,
  output wire [`EPI_CAP_W-1:0]   o_CAP_DATA,
  output wire                    o_CAP_OVERRUN,
  // memory pins
  output wire [`EPI_ADDR_W-1:0]  o_ADDR,
  input  wire [`EPI_DATA_W-1:0]  i_DATA,
  output wire [`EPI_DATA_W-1:0]  o_DATA,
  output wire [`EPI_DATA_W-1:0]  o_DATA_OE,
  output wire                    o_RD_N,
  output wire                    o_WR_N,
  input  wire                    i_ACK,
  input  wire                    i_ACK_DRIVEN,
  output wire [1:0]              o_BANK_SELECT_N,
  output wire                    o_SDRAM_ROW_STROBE_N,
  output wire                    o_SDRAM_COLUMN_STROBE_N,
  output wire                    o_SDRAM_WRITE_N
);
  // access states
  localparam ST_IDLE  = 2'h0;  // no access
  localparam ST_SETUP = 2'h1;  // address and select out, strobes high
  localparam ST_STRB  = 2'h2;  // strobe low, waiting on acknowledge
  localparam ST_DONE  = 2'h3;  // strobe released, one cycle hold
  // setup count at full width, cut to the counter on load
  localparam [31:0] SETUP_CYC = `EPI_SETUP_CYC;

  reg [1:0]              state;        // access state
  reg [1:0]              next_state;   // next access state
  reg [`EPI_ADDR_W-1:0]  addr;         // registered address
  reg [`EPI_DATA_W-1:0]  wdata;        // write data held for the access
  reg                    is_write;     // current access writes
  reg                    rd_n;         // read strobe
  reg                    wr_n;         // write strobe
  reg                    rsp_valid;    // read data valid pulse
  reg [`EPI_DATA_W-1:0]  rdata;        // captured read word
  reg [2:0]              sd_cmd;       // sdram command on the pins
  reg [7:0]              func;         // live function selects
  reg [3:0]              setup_cnt;    // setup cycles left
  reg                    cap_overrun;  // sticky lost capture word
  wire                   ack_eff;      // acknowledge after pull-up
  wire                   active;       // external access in progress
  wire                   cap_in_ready; // fifo fill-side ready
  wire                   cap_sample;   // capture word offered
  integer                i;            // data bit loop index

  // lane function of data bit b
  function [1:0] lane_fn;
    input [7:0] f;
    input integer b;
    begin
      lane_fn = (b < 8)  ? f[1:0] :
                (b < 16) ? f[3:2] :
                (b < 24) ? f[5:4] : f[7:6];
    end
  endfunction

  // undriven acknowledge reads high, like the pin's pull-up
  assign ack_eff = i_ACK | ~i_ACK_DRIVEN;

  // function selects, reset to memory function everywhere
  always @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      func <= 8'h00;
    end else if (i_CE) begin
      func <= i_PIN_FUNC;
    end
  end

  // next state of the access sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE:  if (i_REQ_VALID) next_state = ST_SETUP;
      ST_SETUP: if (setup_cnt == 4'h1) next_state = ST_STRB;
      ST_STRB:  if (ack_eff) next_state = ST_DONE;
      ST_DONE:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  assign o_REQ_READY = (state == ST_IDLE) & i_CE;
  assign active      = (state != ST_IDLE);

  // access sequencer, strobes and data capture
  always @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state     <= ST_IDLE;
      addr      <= {`EPI_ADDR_W{1'b0}};
      wdata     <= {`EPI_DATA_W{1'b0}};
      is_write  <= 1'b0;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
      rsp_valid <= 1'b0;
      rdata     <= {`EPI_DATA_W{1'b0}};
      setup_cnt <= 4'h0;
    end else if (i_CE) begin
      state     <= next_state;
      rsp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_REQ_VALID) begin
            // conditional accesses still run the full cycle
            addr      <= i_REQ_ADDR;
            wdata     <= i_REQ_WDATA;
            is_write  <= i_REQ_WRITE;
            setup_cnt <= SETUP_CYC[3:0];
          end
        end
        ST_SETUP: begin
          setup_cnt <= setup_cnt - 4'h1;
          if (setup_cnt == 4'h1) begin
            // exactly one strobe goes low per word
            rd_n <= is_write;
            wr_n <= ~is_write;
          end
        end
        ST_STRB: begin
          // hold the strobe while acknowledge is low
          if (ack_eff) begin
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            if (!is_write) begin
              rdata     <= i_DATA;
              rsp_valid <= 1'b1;
            end
          end
        end
        ST_DONE: begin
          rd_n <= 1'b1;
          wr_n <= 1'b1;
        end
        default: begin
          rd_n <= 1'b1;
          wr_n <= 1'b1;
        end
      endcase
    end
  end

  // sdram command outputs, nop unless a command is issued
  always @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sd_cmd <= `EPI_SD_NOP;
    end else if (i_CE) begin
      sd_cmd <= i_SD_CMD_VALID ? i_SD_CMD : `EPI_SD_NOP;
    end
  end

  assign o_SDRAM_ROW_STROBE_N    = sd_cmd[2];
  assign o_SDRAM_COLUMN_STROBE_N = sd_cmd[1];
  assign o_SDRAM_WRITE_N         = sd_cmd[0];

  assign o_ADDR      = addr;
  assign o_RD_N      = rd_n;
  assign o_WR_N      = wr_n;
  assign o_RSP_VALID = rsp_valid;
  assign o_RSP_RDATA = rdata;

  // bank select decode, same stage as the address
  epi_bank_dec u_bank (
    .i_active        (active),
    .i_addr          (addr),
    .o_bank_select_n (o_BANK_SELECT_N)
  );

  // data pin multiplexer: drive and enable per bit by lane function
  reg [`EPI_DATA_W-1:0] dout;  // pin output levels
  reg [`EPI_DATA_W-1:0] doe;   // pin output enables
  always @* begin
    dout = {`EPI_DATA_W{1'b0}};
    doe  = {`EPI_DATA_W{1'b0}};
    for (i = 0; i < `EPI_DATA_W; i = i + 1) begin
      case (lane_fn(func, i))
        `EPI_FN_MEM: begin
          dout[i] = wdata[i];
          doe[i]  = is_write & active;
        end
        `EPI_FN_PWM: begin
          dout[i] = i_PWM[i];
          doe[i]  = 1'b1;
        end
        default: begin
          dout[i] = 1'b0;
          doe[i]  = 1'b0;
        end
      endcase
    end
    // lowest four pins always carry the flags
    dout[`EPI_FLAG_N-1:0] = i_FLAG_OUT;
    doe[`EPI_FLAG_N-1:0]  = i_FLAG_OE;
  end

  // registered pin drive
  reg [`EPI_DATA_W-1:0] data_q;  // registered pin levels
  reg [`EPI_DATA_W-1:0] oe_q;    // registered enables
  always @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      data_q <= {`EPI_DATA_W{1'b0}};
      oe_q   <= {`EPI_DATA_W{1'b0}};
    end else if (i_CE) begin
      data_q <= dout;
      oe_q   <= doe;
    end
  end

  assign o_DATA    = data_q;
  assign o_DATA_OE = oe_q;
  assign o_FLAG_IN = i_DATA[`EPI_FLAG_N-1:0];

  // capture offers bits 31-8 every cycle while enabled and lanes 1-3 select it; a full fifo drops the word
  assign cap_sample = i_CAP_ENABLE &
                      (func[7:2] == {`EPI_FN_CAPTURE, `EPI_FN_CAPTURE, `EPI_FN_CAPTURE});

  // sticky overrun when a word is offered to a full fifo
  always @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cap_overrun <= 1'b0;
    end else if (i_CE) begin
      if (cap_sample & ~cap_in_ready) begin
        cap_overrun <= 1'b1;
      end else if (!i_CAP_ENABLE) begin
        cap_overrun <= 1'b0;
      end
    end
  end

  assign o_CAP_OVERRUN = cap_overrun;

  // capture fifo
  epi_fifo #(
    .WIDTH (`EPI_CAP_W),
    .DEPTH (`EPI_FIFO_DEPTH),
    .AW    (`EPI_FIFO_AW)
  ) u_cap_fifo (
    .i_clk       (I_CORE_CLK),
    .i_rstn      (I_RSTN),
    .i_ce        (i_CE),
    .i_in_valid  (cap_sample),
    .o_in_ready  (cap_in_ready),
    .i_in_data   (i_DATA[`EPI_DATA_W-1:`EPI_CAP_LSB]),
    .o_out_valid (o_CAP_VALID),
    .i_out_ready (i_CAP_READY),
    .o_out_data  (o_CAP_DATA)
  );
endmodule // epi_port

// >>> epi_port_sva.sv
// epi_port_sva.sv: pin timing checks for the external port
// assumes a bind to epi_port and a core clock that runs while reset is high
`timescale 1ns/100ps
module epi_port_chk (
  // clock and reset
  input wire        I_CORE_CLK,
  input wire        I_RSTN,
  // core request side
  input wire        i_REQ_VALID,
  input wire        o_REQ_READY,
  input wire        i_REQ_WRITE,
  input wire [23:0] i_REQ_ADDR,
  input wire        o_RSP_VALID,
  input wire        i_SD_CMD_VALID,
  input wire [2:0]  i_SD_CMD,
  // memory pins
  input wire [23:0] o_ADDR,
  input wire        o_RD_N,
  input wire        o_WR_N,
  input wire        i_ACK,
  input wire        i_ACK_DRIVEN,
  input wire [1:0]  o_BANK_SELECT_N,
  input wire        o_SDRAM_ROW_STROBE_N,
  input wire        o_SDRAM_COLUMN_STROBE_N,
  input wire        o_SDRAM_WRITE_N
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  wire take = i_REQ_VALID && o_REQ_READY;  // request taken at this edge
  wire held = i_ACK_DRIVEN && !i_ACK;      // driven low acknowledge asks for a wait
  property p_excl; !(!o_RD_N && !o_WR_N); endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_rd_wait; !o_RD_N && held |=> !o_RD_N; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read ended during wait");
  property p_wr_wait; !o_WR_N && held |=> !o_WR_N; endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write ended during wait");
  property p_rd_done; !o_RD_N && !held |=> o_RD_N && o_RSP_VALID; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read not ended");
  property p_rd_go; take && !i_REQ_WRITE |=> o_RD_N && o_ADDR == $past(i_REQ_ADDR) ##1 !o_RD_N;
  endproperty
  a_rd_go: assert property (p_rd_go) else $error("read start wrong");
  property p_wr_go; take && i_REQ_WRITE |=> o_WR_N ##1 !o_WR_N; endproperty
  a_wr_go: assert property (p_wr_go) else $error("write start wrong");
  property p_sel; take |=> o_BANK_SELECT_N == ($past(i_REQ_ADDR[23]) ? 2'h1 : 2'h2); endproperty
  a_sel: assert property (p_sel) else $error("bank select wrong");
  property p_idle; o_REQ_READY |-> o_BANK_SELECT_N == 2'h3 && o_RD_N && o_WR_N; endproperty
  a_idle: assert property (p_idle) else $error("pins active while idle");
  property p_sd; 1 |=> {o_SDRAM_ROW_STROBE_N, o_SDRAM_COLUMN_STROBE_N, o_SDRAM_WRITE_N}
    == ($past(i_SD_CMD_VALID) ? $past(i_SD_CMD) : 3'h7); endproperty
  a_sd: assert property (p_sd) else $error("sdram command wrong");
  property p_rsp; o_RSP_VALID |=> !o_RSP_VALID; endproperty
  a_rsp: assert property (p_rsp) else $error("response longer than one cycle");
endmodule // epi_port_chk
bind epi_port epi_port_chk u_chk (.I_CORE_CLK, .I_RSTN, .i_REQ_VALID, .o_REQ_READY,
  .i_REQ_WRITE, .i_REQ_ADDR, .o_RSP_VALID, .i_SD_CMD_VALID, .i_SD_CMD, .o_ADDR, .o_RD_N,
  .o_WR_N, .i_ACK, .i_ACK_DRIVEN, .o_BANK_SELECT_N, .o_SDRAM_ROW_STROBE_N,
  .o_SDRAM_COLUMN_STROBE_N, .o_SDRAM_WRITE_N);

// >>> epi_mem_model.sv
// epi_mem_model.sv: slow asynchronous memory on the external port
// assumes strobes change on the rising edge; data is set up on the falling edge
`timescale 1ns/100ps
module epi_mem_model (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rstn,
  // port pins
  input  wire        i_rd_n,
  input  wire        i_wr_n,
  input  wire [23:0] i_addr,
  input  wire [31:0] i_data,
  output wire [31:0] o_data,
  output wire        o_ack,
  output wire        o_ack_driven,
  // test controls
  input  wire [3:0]  i_waits,
  input  wire        i_float,
  input  wire        i_drv_en,
  input  wire [31:0] i_drv_val
);
  reg  [31:0] mem [0:15];  // sixteen words, low address bits only
  reg  [3:0]  cnt;         // cycles the strobe has been low
  reg  [31:0] rd_q;        // read word, inverted while idle
  wire        strb = !i_rd_n || !i_wr_n;
  // a floating acknowledge is left low on purpose to prove it is ignored
  assign o_ack_driven = !i_float;
  assign o_ack = !i_float && (!strb || cnt >= i_waits);
  assign o_data = i_drv_en ? i_drv_val : rd_q;
  // wait counter
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) cnt <= 4'h0;
    else if (strb) cnt <= cnt + 4'h1;
    else cnt <= 4'h0;
  end
  // store on the edge that completes a write
  always @(posedge i_clk) begin
    if (!i_wr_n && o_ack) mem[i_addr[3:0]] <= i_data;
  end
  // released bus alternates each cycle between the inverted and the old word
  always @(negedge i_clk or negedge i_rstn) begin
    if (!i_rstn) rd_q <= 32'h0;
    else rd_q <= !i_rd_n ? mem[i_addr[3:0]] : ~rd_q;
  end
endmodule // epi_mem_model

// >>> test_epi_port.sv
// test_epi_port.sv: self-checking bench for the external port
// assumes epi_port, epi_fifo, epi_bank_dec and the memory model are compiled
`timescale 1ns/100ps
module test_epi_port;
  reg         clk = 1'b0, rstn = 1'b0;
  reg         req_valid = 1'b0, req_write = 1'b0, req_cond = 1'b0;
  reg  [23:0] req_addr = 24'h0;
  reg  [31:0] req_wdata = 32'h0, drv_val = 32'h0;
  reg         sd_valid = 1'b0, cap_en = 1'b0, cap_ready = 1'b0, ack_float = 1'b0, drv_en = 1'b0;
  reg  [2:0]  sd_cmd = 3'h7;
  reg  [7:0]  pin_func = 8'h0;
  reg  [3:0]  waits = 4'h0;
  reg  [3:0]  flag_out = 4'h0;
  reg  [31:0] pwm = 32'h0;
  wire        req_ready, rsp_valid, cap_valid, overrun, rd_n, wr_n, ack, ack_drv, ras, cas, we;
  wire [31:0] rdata, pin_in, pin_out, pin_oe;
  wire [23:0] cap_data, addr;
  wire [1:0]  bsel;
  wire [3:0]  flag_in;
  integer     err_count = 0, checked = 0, seed = 32'hbba3fe1a, i;
  reg  [23:0] adr [0:7];
  reg  [31:0] dat [0:7];
  reg  [31:0] rq [$];  // expected read words
  reg  [23:0] cq [$];  // expected capture words
  epi_port uut (.I_CORE_CLK(clk), .I_RSTN(rstn), .i_CE(1'b1), .i_REQ_VALID(req_valid),
    .o_REQ_READY(req_ready), .i_REQ_WRITE(req_write), .i_REQ_COND(req_cond),
    .i_REQ_ADDR(req_addr), .i_REQ_WDATA(req_wdata), .o_RSP_VALID(rsp_valid),
    .o_RSP_RDATA(rdata), .i_SD_CMD_VALID(sd_valid), .i_SD_CMD(sd_cmd), .i_PIN_FUNC(pin_func),
    .i_CAP_ENABLE(cap_en), .i_FLAG_OUT(flag_out), .i_FLAG_OE(4'hf), .o_FLAG_IN(flag_in),
    .i_PWM(pwm), .o_CAP_VALID(cap_valid), .i_CAP_READY(cap_ready), .o_CAP_DATA(cap_data),
    .o_CAP_OVERRUN(overrun), .o_ADDR(addr), .i_DATA(pin_in), .o_DATA(pin_out),
    .o_DATA_OE(pin_oe), .o_RD_N(rd_n), .o_WR_N(wr_n), .i_ACK(ack), .i_ACK_DRIVEN(ack_drv),
    .o_BANK_SELECT_N(bsel), .o_SDRAM_ROW_STROBE_N(ras), .o_SDRAM_COLUMN_STROBE_N(cas),
    .o_SDRAM_WRITE_N(we));
  epi_mem_model u_mem (.i_clk(clk), .i_rstn(rstn), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_addr(addr), .i_data(pin_out), .o_data(pin_in), .o_ack(ack), .o_ack_driven(ack_drv),
    .i_waits(waits), .i_float(ack_float), .i_drv_en(drv_en), .i_drv_val(drv_val));
  // 40 MHz core clock
  initial forever #12.5 clk = ~clk;
  // compare one value and count it
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // verdict and end of run
  task complete_run;
    begin
      $display("checks=%0d mismatches=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // one access, held until the port takes it
  task acc(input w, input [23:0] a, input [31:0] d);
    integer n;
    begin
      @(negedge clk);
      n = $random(seed);
      req_cond = n[0];
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      n = 0;
      while (req_ready !== 1'b1 && n < 50) begin
        @(negedge clk);
        n = n + 1;
      end
      chk({31'h0, req_ready}, 32'h1);
      @(negedge clk);
      req_valid = 1'b0;
    end
  endtask
  // wait until every expected result has been seen
  task drain;
    integer n;
    begin
      n = 0;
      while (rq.size() + cq.size() != 0 && n < 200) begin
        @(negedge clk);
        n = n + 1;
      end
      chk(rq.size() + cq.size(), 0);
    end
  endtask
  // result watcher
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) chk(rdata, rq.pop_front());
    if (cap_valid === 1'b1 && cap_ready === 1'b1)
      chk({8'h0, cap_data}, {8'h0, cq.pop_front()});
  end
  // watchdog
  initial begin
    #100000;
    err_count = err_count + 1;
    $display("watchdog expired");
    complete_run;
  end
  initial begin
    repeat (6) @(negedge clk);
    chk({25'h0, rd_n, wr_n, bsel, ras, cas, we}, 32'h7f);
    chk(pin_oe, 32'h0);
    rstn = 1'b1;
    $display("reset test done");
    // flag pins replace the low nibble of every written word with flag_out
    dat[0] = $random(seed);
    flag_out = dat[0][3:0];
    for (i = 0; i < 8; i = i + 1) begin
      dat[i] = $random(seed);
      adr[i] = {dat[i][23:4], i[3:0]};
      dat[i] = $random(seed);
      waits = i[3:0];
      acc(1'b1, adr[i], dat[i]);
    end
    for (i = 0; i < 8; i = i + 1) begin
      waits = 4'h7 - i[3:0];
      rq.push_back({dat[i][31:4], flag_out});
      acc(1'b0, adr[i], 32'h0);
    end
    drain;
    $display("access test done");
    ack_float = 1'b1;
    waits = 4'hf;
    rq.push_back({dat[3][31:4], flag_out});
    acc(1'b0, adr[3], 32'h0);
    drain;
    ack_float = 1'b0;
    $display("floating acknowledge test done");
    for (i = 0; i < 7; i = i + 1) begin
      @(negedge clk);
      sd_valid = 1'b1;
      sd_cmd = i[2:0];
      @(negedge clk);
      sd_valid = 1'b0;
      chk({29'h0, ras, cas, we}, i);
    end
    @(negedge clk);
    chk({29'h0, ras, cas, we}, 32'h7);
    $display("sdram command test done");
    pin_func = 8'h54;
    repeat (2) @(negedge clk);
    drv_en = 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      drv_val = $random(seed);
      if (i < 4) cq.push_back(drv_val[31:8]);
      cap_en = 1'b1;
      @(negedge clk);
      chk({28'h0, flag_in}, {28'h0, drv_val[3:0]});
    end
    chk({31'h0, overrun}, 32'h1);
    cap_en = 1'b0;
    drv_en = 1'b0;
    cap_ready = 1'b1;
    drain;
    chk({31'h0, overrun}, 32'h0);
    $display("capture test done");
    // top lane to pwm; flags stay driven on pins 3:0
    pwm = $random(seed);
    pin_func = 8'hc0;
    repeat (2) @(negedge clk);
    chk(pin_oe, 32'hff00000f);
    chk(pin_out & 32'hff00000f, {pwm[31:24], 20'h0, flag_out});
    pin_func = 8'h0;
    $display("pwm test done");
    complete_run;
  end
endmodule // test_epi_port
